// *** rtl/pfrm_pkg.sv ***
// constants, field layouts and types of the power failure restart monitor
// assumes a single 100 MHz pclk and the APB slave in pfrm_power_failure_monitor
package pfrm_pkg;

    // ==================================================================
    // geometry
    localparam int unsigned NUM_DRIVES = 4;
    localparam int unsigned NUM_DEV_IN = 4;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned TIME_W     = 15;
    localparam int unsigned TICK_W     = 24;

    // ==================================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned STEP_NS         = 100_000_000;
    localparam int unsigned TICK_CYCLES_DEF = STEP_NS / CLK_PERIOD_NS;
    // multipliers into 0.1 s steps
    localparam logic [TIME_W-1:0] BAND0_MUL   = 15'h0001;
    localparam logic [TIME_W-1:0] BAND1_MUL   = 15'h000a;
    localparam logic [TIME_W-1:0] BAND2_MUL   = 15'h0064;
    localparam logic [TIME_W-1:0] RESTART_MUL = 15'h000a;

    // ==================================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PF_TIME  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RESTART  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

    // ==================================================================
    // field positions
    localparam int unsigned CTRL_TYPE_BIT = 0;
    localparam int unsigned CTRL_SRC_LSB  = 1;
    localparam int unsigned CTRL_COMM_BIT = 4;
    localparam int unsigned PF_BAND_LSB   = 8;
    localparam int unsigned CMD_RESET_BIT = 0;
    localparam int unsigned ST_OUTAGE_BIT = 0;
    localparam int unsigned ST_DELAY_BIT  = 1;
    localparam int unsigned ST_FAULT_BIT  = 2;
    localparam int unsigned ST_LOSS_BIT   = 3;
    localparam int unsigned ST_CONT_LSB   = 4;
    localparam int unsigned ST_SAVED_LSB  = 8;
    localparam int unsigned EV_OUTAGE     = 0;
    localparam int unsigned EV_RESTORE    = 1;
    localparam int unsigned EV_FAULT      = 2;
    localparam int unsigned NUM_EV        = 3;

    // ==================================================================
    // reset values and encodings
    localparam logic [2:0]        SRC_COMM_BIT = 3'h4;
    localparam logic [7:0]        RST_PF_VALUE = 8'h00;
    localparam logic [1:0]        RST_PF_BAND  = 2'h0;
    localparam logic [7:0]        RST_RESTART  = 8'h00;
    localparam logic [1:0]        BAND_TENTHS  = 2'h0;
    localparam logic [1:0]        BAND_SECONDS = 2'h1;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_OUTAGE,
        ST_DELAY,
        ST_FAULT
    } pfrm_state_e;

endpackage : pfrm_pkg

// *** rtl/pfrm_tick.sv ***
// 0.1 s step enable for the monitor timers
// assumes pclk at the rate that TICK_CYCLES is derived from
`timescale 1ns/1ps
module pfrm_tick
    import pfrm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic restart,
    output logic      tick
);

    // ==================================================================
    // divider
    localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_CYCLES - 1);

    logic [TICK_W-1:0] cnt;
    logic [TICK_W-1:0] next_cnt;

    // restart realigns the step so a timer never loses up to one step at start
    always_comb begin
        if (restart || cnt == LAST) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + TICK_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick = !restart && cnt == LAST;

endmodule : pfrm_tick

// *** rtl/pfrm_timer.sv ***
// step counter compared with a limit given in 0.1 s steps
// assumes a one-cycle step enable and a clear pulse before each run
`timescale 1ns/1ps
module pfrm_timer
    import pfrm_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clear,
    input  wire logic              run,
    input  wire logic              tick,
    input  wire logic [TIME_W-1:0] limit,
    output logic                   expired
);

    // ==================================================================
    // counter
    logic [TIME_W-1:0] cnt;
    logic [TIME_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (clear) begin
            next_cnt = '0;
        end else if (run && tick && !expired) begin
            next_cnt = cnt + TIME_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // a zero limit counts as expired at once
    assign expired = cnt >= limit;

endmodule : pfrm_timer

// *** rtl/pfrm_power_failure_monitor.sv ***
// power failure restart monitor: apb registers, outage sequencer, interrupt
// assumes synchronous inputs on pclk, an apb3 master and a buffered own supply
`timescale 1ns/1ps
module pfrm_power_failure_monitor
    import pfrm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NUM_DEV_IN-1:0] device_inputs,
    input  wire logic [NUM_DRIVES-1:0] run_cmd,
    output logic      [NUM_DRIVES-1:0] contactor_outputs,
    output logic                       fault_latched,
    output logic                       irq
);

    // ==================================================================
    // functions
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = a == OFS_CTRL || a == OFS_PF_TIME || a == OFS_RESTART ||
                      a == OFS_CMD || a == OFS_STATUS || a == OFS_IRQ_STAT ||
                      a == OFS_IRQ_MASK;
    endfunction : addr_mapped

    function automatic logic [TIME_W-1:0] pf_limit(input logic [1:0] band,
                                                   input logic [7:0] value);
        logic [TIME_W-1:0] v;
        v = {7'h00, value};
        case (band)
            BAND_TENTHS:  pf_limit = TIME_W'(v * BAND0_MUL);
            BAND_SECONDS: pf_limit = TIME_W'(v * BAND1_MUL);
            default:      pf_limit = TIME_W'(v * BAND2_MUL);
        endcase
    endfunction : pf_limit

    // ==================================================================
    // register state
    logic                  ctrl_type;
    logic [2:0]            src_sel;
    logic                  comm_loss;
    logic [7:0]            pf_value;
    logic [1:0]            pf_band;
    logic [7:0]            restart_sec;
    logic [NUM_EV-1:0]     irq_stat;
    logic [NUM_EV-1:0]     irq_mask;
    logic [31:0]           rdata;

    logic                  next_ctrl_type;
    logic [2:0]            next_src_sel;
    logic                  next_comm_loss;
    logic [7:0]            next_pf_value;
    logic [1:0]            next_pf_band;
    logic [7:0]            next_restart_sec;
    logic [NUM_EV-1:0]     next_irq_stat;
    logic [NUM_EV-1:0]     next_irq_mask;
    logic [31:0]           next_rdata;

    // sequencer state
    pfrm_state_e           state;
    pfrm_state_e           next_state;
    logic [NUM_DRIVES-1:0] run_q;
    logic [NUM_DRIVES-1:0] next_run_q;
    logic [NUM_DRIVES-1:0] saved;
    logic [NUM_DRIVES-1:0] next_saved;

    logic                  wr_en;
    logic                  rd_setup;
    logic                  reset_cmd;
    logic                  src_level;
    logic                  loss_now;
    logic                  pf_clear;
    logic                  dly_clear;
    logic                  tick;
    logic                  pf_expired;
    logic                  dly_expired;
    logic [NUM_EV-1:0]     events;
    logic [31:0]           status_word;

    // ==================================================================
    // apb handshake: zero wait states, read data captured in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_mapped(paddr);
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata   = rdata;
    assign reset_cmd = wr_en && paddr == OFS_CMD && pwdata[CMD_RESET_BIT];

    // ==================================================================
    // activation source
    always_comb begin
        if (src_sel == SRC_COMM_BIT) begin
            src_level = comm_loss;
        end else if (src_sel < SRC_COMM_BIT) begin
            src_level = device_inputs[src_sel[1:0]];
        end else begin
            src_level = 1'b0;
        end
    end

    // with monitoring off the input is ignored entirely
    assign loss_now = ctrl_type && src_level;

    // ==================================================================
    // status word
    always_comb begin
        status_word = '0;
        status_word[ST_OUTAGE_BIT] = state == ST_OUTAGE;
        status_word[ST_DELAY_BIT]  = state == ST_DELAY;
        status_word[ST_FAULT_BIT]  = state == ST_FAULT;
        status_word[ST_LOSS_BIT]   = loss_now;
        status_word[ST_CONT_LSB +: NUM_DRIVES]  = contactor_outputs;
        status_word[ST_SAVED_LSB +: NUM_DRIVES] = saved;
    end

    // ==================================================================
    // register file
    always_comb begin
        next_ctrl_type   = ctrl_type;
        next_src_sel     = src_sel;
        next_comm_loss   = comm_loss;
        next_pf_value    = pf_value;
        next_pf_band     = pf_band;
        next_restart_sec = restart_sec;
        next_irq_mask    = irq_mask;
        next_irq_stat    = irq_stat;
        next_rdata       = rdata;
        if (wr_en) begin
            case (paddr)
                OFS_CTRL: begin
                    next_ctrl_type = pwdata[CTRL_TYPE_BIT];
                    next_src_sel   = pwdata[CTRL_SRC_LSB +: 3];
                    next_comm_loss = pwdata[CTRL_COMM_BIT];
                end
                OFS_PF_TIME: begin
                    next_pf_value = pwdata[7:0];
                    next_pf_band  = pwdata[PF_BAND_LSB +: 2];
                end
                OFS_RESTART: begin
                    next_restart_sec = pwdata[7:0];
                end
                OFS_IRQ_STAT: begin
                    next_irq_stat = irq_stat & ~pwdata[NUM_EV-1:0];
                end
                OFS_IRQ_MASK: begin
                    next_irq_mask = pwdata[NUM_EV-1:0];
                end
                default: begin
                end
            endcase
        end
        // a new event wins over a write-one clear in the same cycle
        next_irq_stat = next_irq_stat | events;
        if (rd_setup) begin
            case (paddr)
                OFS_CTRL:     next_rdata = {27'h0, comm_loss, src_sel, ctrl_type};
                OFS_PF_TIME:  next_rdata = {22'h0, pf_band, pf_value};
                OFS_RESTART:  next_rdata = {24'h0, restart_sec};
                OFS_STATUS:   next_rdata = status_word;
                OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
                OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
                default:      next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_type   <= 1'b0;
            src_sel     <= 3'h0;
            comm_loss   <= 1'b0;
            pf_value    <= RST_PF_VALUE;
            pf_band     <= RST_PF_BAND;
            restart_sec <= RST_RESTART;
            irq_stat    <= '0;
            irq_mask    <= '0;
            rdata       <= 32'h0000_0000;
        end else begin
            ctrl_type   <= next_ctrl_type;
            src_sel     <= next_src_sel;
            comm_loss   <= next_comm_loss;
            pf_value    <= next_pf_value;
            pf_band     <= next_pf_band;
            restart_sec <= next_restart_sec;
            irq_stat    <= next_irq_stat;
            irq_mask    <= next_irq_mask;
            rdata       <= next_rdata;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==================================================================
    // outage sequencer
    always_comb begin
        next_state = state;
        next_run_q = run_q;
        next_saved = saved;
        pf_clear   = 1'b0;
        dly_clear  = 1'b0;
        events     = '0;
        case (state)
            ST_NORMAL: begin
                if (loss_now) begin
                    next_saved = run_q;
                    next_run_q = '0;
                    pf_clear   = 1'b1;
                    next_state = ST_OUTAGE;
                    events[EV_OUTAGE] = 1'b1;
                end else begin
                    next_run_q = run_cmd;
                end
            end
            ST_OUTAGE: begin
                // a return seen in the cycle of expiry still counts as in time
                if (!loss_now) begin
                    if (restart_sec == 8'h00) begin
                        next_run_q = saved;
                        next_state = ST_NORMAL;
                        events[EV_RESTORE] = 1'b1;
                    end else begin
                        dly_clear  = 1'b1;
                        next_state = ST_DELAY;
                    end
                end else if (pf_expired) begin
                    next_run_q = '0;
                    next_saved = '0;
                    next_state = ST_FAULT;
                    events[EV_FAULT] = 1'b1;
                end
            end
            ST_DELAY: begin
                if (loss_now) begin
                    pf_clear   = 1'b1;
                    next_state = ST_OUTAGE;
                    events[EV_OUTAGE] = 1'b1;
                end else if (dly_expired) begin
                    next_run_q = saved;
                    next_state = ST_NORMAL;
                    events[EV_RESTORE] = 1'b1;
                end
            end
            ST_FAULT: begin
                next_run_q = '0;
                // after the reset the drives follow run_cmd again from the next cycle; saved is not restored
                if (reset_cmd && !loss_now) begin
                    next_state = ST_NORMAL;
                end
            end
            default: begin
                next_run_q = '0;
                next_state = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_NORMAL;
            run_q <= '0;
            saved <= '0;
        end else begin
            state <= next_state;
            run_q <= next_run_q;
            saved <= next_saved;
        end
    end

    // combinational gate so the drop needs no clock edge
    assign contactor_outputs = run_q & {NUM_DRIVES{!loss_now}};
    assign fault_latched     = state == ST_FAULT;

    // ==================================================================
    // timers share one step divider; they never run at the same time
    pfrm_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (pf_clear || dly_clear),
        .tick    (tick)
    );

    pfrm_timer u_pf_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (pf_clear),
        .run     (state == ST_OUTAGE),
        .tick    (tick),
        .limit   (pf_limit(pf_band, pf_value)),
        .expired (pf_expired)
    );

    pfrm_timer u_dly_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (dly_clear),
        .run     (state == ST_DELAY),
        .tick    (tick),
        .limit   (TIME_W'({7'h00, restart_sec} * RESTART_MUL)),
        .expired (dly_expired)
    );

endmodule : pfrm_power_failure_monitor

// *** test/pfrm_checker_assertions.sv ***
// concurrent checks of the power failure restart monitor
// sees only the top ports; shadows ctrl and mask from completed apb writes
`timescale 1ns/1ps
module pfrm_checker
    import pfrm_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_W-1:0]     paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [NUM_DEV_IN-1:0] device_inputs,
    input wire logic [NUM_DRIVES-1:0] run_cmd,
    input wire logic [NUM_DRIVES-1:0] contactor_outputs,
    input wire logic                  fault_latched,
    input wire logic                  irq
);
    // ==========
    // shadow state
    logic [4:0] ctrl;
    logic [2:0] mask;
    logic       wr, bad, loss;
    assign wr   = psel && penable && pwrite && pready;
    assign bad  = (paddr[1:0] != 2'h0) || (paddr > OFS_IRQ_MASK);
    // sources 5..7 never activate
    assign loss = ctrl[0] && (ctrl[3] ? (ctrl[3:1] == SRC_COMM_BIT && ctrl[4])
                                      : device_inputs[ctrl[2:1]]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 5'h00;
            mask <= 3'h0;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl <= pwdata[4:0];
        end else if (wr && paddr == OFS_IRQ_MASK) begin
            mask <= pwdata[2:0];
        end
    end

    // ==========
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    AST_SLVERR: assert property (psel && penable |-> pslverr == bad)
        else $error("pslverr wrong for address");
    AST_SLVERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    AST_DROP: assert property (loss |-> contactor_outputs == 4'h0)
        else $error("contactors on during loss");
    AST_FAULT_OFF: assert property (fault_latched |-> contactor_outputs == 4'h0)
        else $error("contactors on while faulted");
    AST_FAULT_HOLD: assert property (fault_latched && loss |=> fault_latched)
        else $error("fault cleared during loss");
    AST_FAULT_CLR: assert property (fault_latched && !loss && wr && paddr == OFS_CMD
        && pwdata[CMD_RESET_BIT] |=> !fault_latched)
        else $error("fault not cleared by reset command");
    AST_FAULT_CAUSE: assert property ($rose(fault_latched) |-> $past(loss))
        else $error("fault without outage");
    AST_TYPE_OFF: assert property ($rose(fault_latched) |-> $past(ctrl[0]))
        else $error("fault while monitoring off");
    AST_IRQ_MASK: assert property (mask == 3'h0 && $past(mask) == 3'h0 |-> !irq)
        else $error("irq with all masked");

    cover property ($rose(fault_latched));
    cover property ($fell(fault_latched));
    cover property (loss ##1 !loss);
    cover property ($rose(irq));
endmodule : pfrm_checker

bind pfrm_power_failure_monitor pfrm_checker u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .device_inputs, .run_cmd, .contactor_outputs, .fault_latched, .irq);

// *** test/pfrm_line_relay.sv ***
// behavioural line voltage relay feeding the loss inputs
// assumes the bench sets line_down and chan just after a rising edge
`timescale 1ns/1ps
module pfrm_line_relay
    import pfrm_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  line_down,
    input  wire logic [1:0]            chan,
    output logic      [NUM_DEV_IN-1:0] device_inputs
);
    // contact closes on line loss; other channels stay open, no false trips
    always @(posedge pclk) begin
        device_inputs        <= 4'h0;
        device_inputs[chan]  <= line_down;
    end
endmodule : pfrm_line_relay

// *** test/test_pfrm_power_failure_monitor.sv ***
// self-checking bench of the power failure restart monitor
// assumes a 5 cycle step divider and the relay model on the loss inputs
`timescale 1ns/1ps
module test_pfrm_power_failure_monitor;
    import pfrm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        fault_latched, irq, line_down;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  device_inputs, run_cmd, contactor_outputs;
    logic [1:0]  chan;
    int          miscompares, checked, n;

    pfrm_power_failure_monitor #(.TICK_CYCLES(5)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .device_inputs, .run_cmd, .contactor_outputs, .fault_latched, .irq);
    pfrm_line_relay u_relay (.pclk, .line_down, .chan, .device_inputs);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==========
    // helpers
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : cyc

    // one apb transfer; data and error taken at the edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            check("pready", 1, 0);
            finish_test();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        check("write error", 0, e);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check($sformatf("read %h", a), exp, q);
        check($sformatf("error %h", a), experr, e);
    endtask : rdc

    task automatic line(input logic v);
        @(posedge pclk);
        line_down <= v;
    endtask : line

    task automatic drive(input logic [3:0] v);
        @(posedge pclk);
        run_cmd <= v;
    endtask : drive

    task automatic blip(input int k);
        line(1'b1);
        cyc(k);
        line(1'b0);
    endtask : blip

    // what 0: contactor pattern, 1: fault level; n counts cycles waited
    task automatic wait_for(input int what, input logic [3:0] v, input int max);
        #1;
        n = 0;
        while (!(what == 0 ? contactor_outputs === v : fault_latched === v[0])) begin
            @(posedge pclk);
            #1;
            n++;
            if (n > max) begin
                check("wait bound", 0, 1);
                finish_test();
            end
        end
    endtask : wait_for

    // ==========
    // scenarios
    task automatic t_reset();
        logic [7:0] ofs [6] = '{OFS_CTRL, OFS_PF_TIME, OFS_RESTART, OFS_STATUS,
                                OFS_IRQ_STAT, OFS_IRQ_MASK};
        foreach (ofs[i]) rdc(ofs[i], 32'h0, 1'b0);
        rdc(8'h1c, 32'h0, 1'b1);
        rdc(8'h02, 32'h0, 1'b1);
    endtask : t_reset

    task automatic t_off();
        drive(4'h5);
        line(1'b1);
        cyc(4);
        check("type off", 4'h5, contactor_outputs);
        line(1'b0);
    endtask : t_off

    task automatic t_restore();
        wr(OFS_CTRL, 32'h1);
        wr(OFS_PF_TIME, 32'h0a);
        drive(4'ha);
        cyc(3);
        line(1'b1);
        cyc(1);
        check("drop", 4'h0, contactor_outputs);
        drive(4'h0);
        rdc(OFS_STATUS, 32'h0a09, 1'b0);
        line(1'b0);
        wait_for(0, 4'ha, 10);
        drive(4'ha);
        rdc(OFS_IRQ_STAT, 32'h3, 1'b0);
        wr(OFS_IRQ_STAT, 32'h7);
        wait_for(0, 4'ha, 5);
    endtask : t_restore

    task automatic t_delay();
        wr(OFS_RESTART, 32'h1);
        blip(5);
        wait_for(0, 4'ha, 80);
        check("delay", 1, n >= 46 && n <= 62);
        blip(5);
        cyc(20);
        blip(5);
        wait_for(0, 4'ha, 80);
        check("cancel", 1, n >= 46 && n <= 62);
        wr(OFS_RESTART, 32'h0);
    endtask : t_delay

    task automatic t_fault();
        wr(OFS_PF_TIME, 32'h04);
        line(1'b1);
        wait_for(1, 4'h1, 60);
        check("expiry", 1, n >= 18 && n <= 30);
        wr(OFS_CMD, 32'h1);
        cyc(2);
        check("reset in loss", 1, fault_latched);
        line(1'b0);
        cyc(10);
        check("no auto", 4'h0, contactor_outputs);
        wr(OFS_CMD, 32'h1);
        wait_for(1, 4'h0, 3);
        wait_for(0, 4'ha, 5);
    endtask : t_fault

    task automatic t_band();
        logic [31:0] set [2] = '{32'h101, 32'h201};
        int          lim [2] = '{50, 500};
        foreach (set[i]) begin
            wr(OFS_PF_TIME, set[i]);
            line(1'b1);
            wait_for(1, 4'h1, lim[i] + 40);
            check("band", 1, n >= lim[i] - 4 && n <= lim[i] + 10);
            line(1'b0);
            cyc(2);
            wr(OFS_CMD, 32'h1);
            wait_for(0, 4'ha, 5);
        end
    endtask : t_band

    task automatic t_src();
        wr(OFS_CTRL, 32'h09);
        cyc(2);
        check("bus bit idle", 4'ha, contactor_outputs);
        wr(OFS_CTRL, 32'h19);
        #1;
        check("bus bit loss", 4'h0, contactor_outputs);
        wr(OFS_CTRL, 32'h09);
        wait_for(0, 4'ha, 5);
        chan <= 2'h1;
        wr(OFS_CTRL, 32'h03);
        line(1'b1);
        cyc(1);
        check("input 1", 4'h0, contactor_outputs);
        line(1'b0);
        wait_for(0, 4'ha, 10);
        chan <= 2'h0;
        wr(OFS_CTRL, 32'h01);
    endtask : t_src

    task automatic t_irq();
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_MASK, 32'h1);
        blip(3);
        wait_for(0, 4'ha, 10);
        cyc(1);
        check("irq set", 1, irq);
        rdc(OFS_IRQ_STAT, 32'h3, 1'b0);
        wr(OFS_IRQ_MASK, 32'h0);
        cyc(2);
        check("irq masked", 0, irq);
        wr(OFS_IRQ_MASK, 32'h2);
        cyc(2);
        check("irq restore", 1, irq);
        wr(OFS_IRQ_STAT, 32'h2);
        cyc(2);
        check("irq cleared", 0, irq);
        rdc(OFS_IRQ_STAT, 32'h1, 1'b0);
    endtask : t_irq

    // ==========
    // main sequence and watchdog
    initial begin
        {psel, penable, pwrite, line_down, presetn} = 5'h00;
        {paddr, pwdata, run_cmd, chan} = 46'h0;
        miscompares = 0;
        checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_off();
        t_restore();
        t_delay();
        t_fault();
        t_band();
        t_src();
        t_irq();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        check("run bound", 0, 1);
        finish_test();
    end
endmodule : test_pfrm_power_failure_monitor
